// ---- logic/soac_ctrl.sv ----
/*
 Overhead alarm control of a 155 Mbit/s SONET / SDH framer.
 Assumes all inputs come from framer logic on clk_sys; frame_start
 and rx_g1_valid pulse once per frame.
*/
// What this block does
// (R1) SONET framing loads pointer size bits with 00.
// (R2) SDH framing loads pointer size bits with 10.
// (R3) SONET path remote defect sends 1001 in G1 remote-error bits.
// (R4) SDH path remote defect sets G1 bit 5.
// (R5) SDH declares path remote defect after five consecutive frames.
// (R6) SONET records yellow from G1 bit 5 after ten frames.
// (R7) SONET detects path remote defect from remote-error bits.
// (R8) SDH disables yellow detection and generation.
// (R9) Pointer size override accepts all four codes in either framing.
// (R10) Pointer size override takes effect at once.
// (R11) Auto yellow in SONET sends yellow on LOS, LOF, AIS, LOP.
// (R12) Auto line remote defect sends FERF on LOS, LOF, line AIS.
// (R13) Auto remote error sends line and path FEBE from BIP errors.
// (R14) Auto option off: indicator lit, nothing transmitted.
// (R15) BIP errors are always accumulated for monitoring.
// (R16) Yellow indication exists only in SONET framing.
// (R17) Framing change reloads pointer size default; override persists.
// (R18) Auto enables reset off; configuration applies at frame start.
`timescale 1ns/10ps
module soac_ctrl (
    // Clock and reset
    input  logic        clk_sys,
    input  logic        reset,
    // Configuration
    input  logic        framing_sdh,
    input  logic [1:0]  s_bits_override_value,
    input  logic        s_bits_override_write,
    input  logic        path_yellow_auto_enable,
    input  logic        line_remote_defect_auto_enable,
    input  logic        remote_error_auto_enable,
    input  logic        path_rdi_request,
    // Frame timing
    input  logic        frame_start,
    // Receive side
    input  logic [7:0]  rx_g1,
    input  logic        rx_g1_valid,
    input  logic        los,
    input  logic        lof,
    input  logic        line_ais,
    input  logic        lop,
    input  logic        path_ais,
    input  logic        line_bip_error,
    input  logic        path_bip_error,
    // Transmit overhead
    output logic [1:0]  tx_s_bits,
    output logic [7:0]  tx_g1,
    output logic        tx_line_ferf,
    output logic [4:0]  tx_line_febe,
    // Status
    output logic        framing_sdh_active,
    output logic [4:0]  defect_indicator,
    output logic        path_rdi_alarm,
    output logic        path_yellow_alarm,
    output logic [15:0] line_bip_total,
    output logic [15:0] path_bip_total
);
    import soac_pkg::*;

    function automatic logic [1:0] default_s_bits(input logic sdh);
        default_s_bits = sdh ? S_BITS_SDH : S_BITS_SONET;
    endfunction : default_s_bits

    function automatic logic [15:0] sat_inc16(input logic [15:0] v);
        sat_inc16 = (v == TOTAL_MAX) ? v : v + 16'h0001;
    endfunction : sat_inc16

    // Configuration registers
    logic        sdh_reg, sdh_next;
    logic        py_auto_reg, py_auto_next;
    logic        lr_auto_reg, lr_auto_next;
    logic        re_auto_reg, re_auto_next;
    logic [1:0]  s_bits_reg, s_bits_next;
    logic        framing_change;

    always_comb begin
        sdh_next       = sdh_reg;
        py_auto_next   = py_auto_reg;
        lr_auto_next   = lr_auto_reg;
        re_auto_next   = re_auto_reg;
        s_bits_next    = s_bits_reg;
        framing_change = frame_start && (framing_sdh != sdh_reg);
        if (frame_start) begin // R18
            sdh_next     = framing_sdh;
            py_auto_next = path_yellow_auto_enable;
            lr_auto_next = line_remote_defect_auto_enable;
            re_auto_next = remote_error_auto_enable;
        end
        if (framing_change) begin
            s_bits_next = default_s_bits(framing_sdh); // R1 R2 R17
        end
        if (s_bits_override_write) begin
            s_bits_next = s_bits_override_value; // R9 R10
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sdh_reg     <= CFG_RESET;
            py_auto_reg <= CFG_RESET;
            lr_auto_reg <= CFG_RESET;
            re_auto_reg <= CFG_RESET;
            s_bits_reg  <= S_BITS_SONET;
        end else begin
            sdh_reg     <= sdh_next;
            py_auto_reg <= py_auto_next;
            lr_auto_reg <= lr_auto_next;
            re_auto_reg <= re_auto_next;
            s_bits_reg  <= s_bits_next;
        end
    end

    // Received G1 persistence
    soac_persist_if rdi_pif ();
    soac_persist_if yel_pif ();

    assign rdi_pif.frame_tick    = rx_g1_valid;
    assign rdi_pif.cond          = sdh_reg ? rx_g1[G1_RDI_BIT] // R5
        : (rx_g1[G1_REI_MSB:G1_REI_LSB] == G1_RDI_SONET); // R7
    assign rdi_pif.clear         = framing_change;
    assign rdi_pif.frames_needed = RDI_FRAMES;

    assign yel_pif.frame_tick    = rx_g1_valid;
    assign yel_pif.cond          = !sdh_reg && rx_g1[G1_RDI_BIT]; // R6 R8
    assign yel_pif.clear         = framing_change;
    assign yel_pif.frames_needed = YELLOW_FRAMES;

    soac_persist u_rdi (
        .clk_sys (clk_sys),
        .reset   (reset),
        .pif     (rdi_pif.counter)
    );

    soac_persist u_yel (
        .clk_sys (clk_sys),
        .reset   (reset),
        .pif     (yel_pif.counter)
    );

    // Defects, alarms and error accumulation
    logic        ferf_cond;
    logic        yel_cond;
    logic [4:0]  ind_reg, ind_next;
    logic        ferf_reg, ferf_next;
    logic [7:0]  g1_reg, g1_next;
    logic [3:0]  p_err_reg, p_err_next;
    logic [4:0]  l_err_reg, l_err_next;
    logic [3:0]  p_febe_reg, p_febe_next;
    logic [4:0]  l_febe_reg, l_febe_next;
    logic [15:0] l_tot_reg, l_tot_next;
    logic [15:0] p_tot_reg, p_tot_next;

    assign ferf_cond = los || lof || line_ais;
    assign yel_cond  = ferf_cond || lop || path_ais;

    always_comb begin
        ind_next = '0;
        ind_next[DEF_LOS]  = los; // R14
        ind_next[DEF_LOF]  = lof;
        ind_next[DEF_LAIS] = line_ais;
        ind_next[DEF_LOP]  = lop;
        ind_next[DEF_PAIS] = path_ais;
        ferf_next = lr_auto_reg && ferf_cond; // R12 R14
        // Per-frame BIP error counts, saturating
        p_err_next = p_err_reg;
        l_err_next = l_err_reg;
        p_febe_next = p_febe_reg;
        l_febe_next = l_febe_reg;
        if (frame_start) begin
            p_febe_next = re_auto_reg ? p_err_reg : 4'h0; // R13 R14
            l_febe_next = re_auto_reg ? l_err_reg : 5'h00; // R13 R14
            p_err_next  = 4'h0;
            l_err_next  = 5'h00;
        end
        if (path_bip_error && p_err_next != PATH_FEBE_MAX) begin
            p_err_next = p_err_next + 4'h1;
        end
        if (line_bip_error && l_err_next != LINE_FEBE_MAX) begin
            l_err_next = l_err_next + 5'h01;
        end
        // Running totals regardless of auto setting
        l_tot_next = line_bip_error ? sat_inc16(l_tot_reg) : l_tot_reg;
        p_tot_next = path_bip_error ? sat_inc16(p_tot_reg) : p_tot_reg;
        // Transmitted G1
        g1_next = G1_RESET;
        g1_next[G1_REI_MSB:G1_REI_LSB] = p_febe_reg;
        if (sdh_reg) begin
            g1_next[G1_RDI_BIT] = path_rdi_request; // R4 R8
        end else begin
            if (path_rdi_request) begin
                g1_next[G1_REI_MSB:G1_REI_LSB] = G1_RDI_SONET; // R3
            end
            g1_next[G1_RDI_BIT] = py_auto_reg && yel_cond; // R11 R14
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ind_reg    <= 5'h00;
            ferf_reg   <= 1'h0;
            g1_reg     <= G1_RESET;
            p_err_reg  <= 4'h0;
            l_err_reg  <= 5'h00;
            p_febe_reg <= 4'h0;
            l_febe_reg <= 5'h00;
            l_tot_reg  <= 16'h0000;
            p_tot_reg  <= 16'h0000;
        end else begin
            ind_reg    <= ind_next;
            ferf_reg   <= ferf_next;
            g1_reg     <= g1_next;
            p_err_reg  <= p_err_next;
            l_err_reg  <= l_err_next;
            p_febe_reg <= p_febe_next;
            l_febe_reg <= l_febe_next;
            l_tot_reg  <= l_tot_next; // R15
            p_tot_reg  <= p_tot_next; // R15
        end
    end

    // Outputs
    assign tx_s_bits          = s_bits_reg;
    assign tx_g1              = g1_reg;
    assign tx_line_ferf       = ferf_reg;
    assign tx_line_febe       = l_febe_reg;
    assign framing_sdh_active = sdh_reg;
    assign defect_indicator   = ind_reg;
    assign path_rdi_alarm     = rdi_pif.declared;
    assign path_yellow_alarm  = yel_pif.declared && !sdh_reg; // R16
    assign line_bip_total     = l_tot_reg;
    assign path_bip_total     = p_tot_reg;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sonet_sbits_a: assert property ( // R1
        frame_start && !framing_sdh && sdh_reg && !s_bits_override_write
        |=> tx_s_bits == S_BITS_SONET)
        else $error("SONET default pointer size bits not loaded");
    sdh_sbits_a: assert property ( // R2
        frame_start && framing_sdh && !sdh_reg && !s_bits_override_write
        |=> tx_s_bits == S_BITS_SDH)
        else $error("SDH default pointer size bits not loaded");
    sbits_override_a: assert property ( // R10
        s_bits_override_write |=> tx_s_bits == $past(s_bits_override_value))
        else $error("Pointer size override not applied at once");
    sbits_hold_a: assert property ( // R17
        !s_bits_override_write && !framing_change |=> $stable(tx_s_bits))
        else $error("Pointer size bits changed without cause");
    sonet_rdi_tx_a: assert property ( // R3
        !sdh_reg && path_rdi_request
        |=> tx_g1[G1_REI_MSB:G1_REI_LSB] == G1_RDI_SONET)
        else $error("SONET remote defect pattern not sent");
    sdh_rdi_tx_a: assert property ( // R4
        sdh_reg && path_rdi_request |=> tx_g1[G1_RDI_BIT])
        else $error("SDH remote defect bit not sent");
    sdh_no_yellow_a: assert property ( // R8
        sdh_reg && !path_rdi_request |=> !tx_g1[G1_RDI_BIT])
        else $error("Bit 5 driven in SDH without remote defect");
    rdi_persist_a: assert property ( // R5
        $rose(path_rdi_alarm)
        |-> $past(rdi_pif.frames_seen) == RDI_FRAMES - 4'h1)
        else $error("Remote defect declared at wrong frame count");
    yel_persist_a: assert property ( // R6
        $rose(path_yellow_alarm)
        |-> $past(yel_pif.frames_seen) == YELLOW_FRAMES - 4'h1)
        else $error("Yellow recorded at wrong frame count");
    yel_sonet_a: assert property ( // R16
        path_yellow_alarm
        |-> !framing_sdh_active && yel_pif.frames_seen >= YELLOW_FRAMES)
        else $error("Yellow indication outside SONET");
    auto_yellow_a: assert property ( // R11
        !sdh_reg && py_auto_reg && yel_cond |=> tx_g1[G1_RDI_BIT])
        else $error("Automatic yellow not sent");
    auto_ferf_a: assert property ( // R12
        lr_auto_reg && ferf_cond |=> tx_line_ferf)
        else $error("Automatic line FERF not sent");
    ferf_off_a: assert property ( // R14
        !lr_auto_reg ##1 !lr_auto_reg && los |=> !tx_line_ferf
        && defect_indicator[DEF_LOS])
        else $error("FERF sent or indicator dark while disabled");
    febe_off_a: assert property ( // R14
        frame_start && !re_auto_reg |=> tx_line_febe == 5'h00)
        else $error("FEBE sent while disabled");
    febe_on_a: assert property ( // R13
        frame_start && re_auto_reg |=> tx_line_febe == $past(l_err_reg))
        else $error("Line FEBE count not sent");
    bip_total_a: assert property ( // R15
        path_bip_error && path_bip_total != TOTAL_MAX
        |=> path_bip_total == $past(path_bip_total) + 16'h0001)
        else $error("Path BIP error not accumulated");
    cfg_sync_a: assert property ( // R18
        !frame_start |=> $stable(framing_sdh_active))
        else $error("Framing changed away from frame start");

    override_c: cover property (
        framing_sdh_active && s_bits_override_write
        && s_bits_override_value == 2'h1);
    rdi_c: cover property ($rose(path_rdi_alarm) && framing_sdh_active);
    yellow_c: cover property ($rose(path_yellow_alarm));
    ferf_c: cover property ($rose(tx_line_ferf));

endmodule : soac_ctrl

// ---- logic/soac_pkg.sv ----
/*
 Constants and types of the overhead alarm control block.
 Assumes nothing of its surroundings.
*/
package soac_pkg;

    // Pointer size bit defaults
    localparam logic [1:0]  S_BITS_SONET  = 2'h0;
    localparam logic [1:0]  S_BITS_SDH    = 2'h2;

    // G1 layout, bit 7 is the first transmitted bit
    localparam int          G1_REI_MSB    = 7;
    localparam int          G1_REI_LSB    = 4;
    localparam int          G1_RDI_BIT    = 3;
    localparam logic [3:0]  G1_RDI_SONET  = 4'h9;

    // Persistence in frames
    localparam logic [3:0]  RDI_FRAMES    = 4'h5;
    localparam logic [3:0]  YELLOW_FRAMES = 4'ha;

    // Error count limits
    localparam logic [3:0]  PATH_FEBE_MAX = 4'h8;
    localparam logic [4:0]  LINE_FEBE_MAX = 5'h18;
    localparam logic [15:0] TOTAL_MAX     = 16'hffff;

    // Reset values
    localparam logic        CFG_RESET     = 1'h0;
    localparam logic [7:0]  G1_RESET      = 8'h00;

    // Defect indicator positions
    localparam int          DEF_LOS       = 4;
    localparam int          DEF_LOF       = 3;
    localparam int          DEF_LAIS      = 2;
    localparam int          DEF_LOP       = 1;
    localparam int          DEF_PAIS      = 0;

    // Persistence checker states
    typedef enum logic [2:0] {
        PST_IDLE  = 3'b001,
        PST_COUNT = 3'b010,
        PST_DECL  = 3'b100
    } soac_persist_e;

endpackage : soac_pkg

// ---- logic/soac_persist_if.sv ----
/*
 Link between the controller and one persistence checker.
 Assumes both ends run on clk_sys.
*/
`timescale 1ns/10ps
interface soac_persist_if;
    logic       frame_tick;
    logic       cond;
    logic       clear;
    logic [3:0] frames_needed;
    logic       declared;
    logic [3:0] frames_seen;

    modport owner (
        output frame_tick, cond, clear, frames_needed,
        input  declared, frames_seen
    );
    modport counter (
        input  frame_tick, cond, clear, frames_needed,
        output declared, frames_seen
    );
endinterface : soac_persist_if

// ---- logic/soac_persist.sv ----
/*
 Frame count persistence checker for one received condition.
 Assumes frame_tick pulses once per received G1 byte.
*/
`timescale 1ns/10ps
module soac_persist (
    // Clock and reset
    input  logic                 clk_sys,
    input  logic                 reset,
    // Condition link
    soac_persist_if.counter      pif
);
    import soac_pkg::*;

    soac_persist_e state_reg;
    soac_persist_e state_next;
    logic [3:0]    cnt_reg;
    logic [3:0]    cnt_next;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            PST_IDLE, PST_COUNT: begin
                if (pif.frame_tick) begin
                    if (pif.cond) begin
                        cnt_next   = cnt_reg + 4'h1;
                        state_next = (cnt_next >= pif.frames_needed)
                                   ? PST_DECL : PST_COUNT;
                    end else begin
                        cnt_next   = 4'h0;
                        state_next = PST_IDLE;
                    end
                end
            end
            PST_DECL: begin
                if (pif.frame_tick && !pif.cond) begin
                    cnt_next   = 4'h0;
                    state_next = PST_IDLE;
                end
            end
            default: begin
                cnt_next   = 4'h0;
                state_next = PST_IDLE;
            end
        endcase
        if (pif.clear) begin
            cnt_next   = 4'h0;
            state_next = PST_IDLE;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_reg <= PST_IDLE;
            cnt_reg   <= 4'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign pif.declared    = (state_reg == PST_DECL);
    assign pif.frames_seen = cnt_reg;

endmodule : soac_persist

// ---- dv/soac_far_end.sv ----
/*
 Far-end line equipment model: frame timing and received G1 stream.
 Assumes the bench sets the G1 value to send; one frame every FRAME_CYC.
*/
`timescale 1ns/10ps
module soac_far_end #(
    parameter int FRAME_CYC = 40
) (
    // Clock and reset
    input  logic       clk_sys,
    input  logic       reset,
    // Bench control
    input  logic [7:0] g1_value,
    // Frame stream
    output logic       frame_start,
    output logic [7:0] rx_g1,
    output logic       rx_g1_valid
);
    logic [7:0] cyc_reg;

    // Between valids the G1 lines toggle, so stale data never looks held
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cyc_reg     <= 8'h00;
            frame_start <= 1'b0;
            rx_g1_valid <= 1'b0;
            rx_g1       <= 8'h00;
        end else begin
            cyc_reg     <= (cyc_reg == 8'(FRAME_CYC - 1)) ? 8'h00
                                                          : cyc_reg + 8'h01;
            frame_start <= (cyc_reg == 8'(FRAME_CYC - 1));
            rx_g1_valid <= (cyc_reg == 8'h03);
            rx_g1       <= (cyc_reg == 8'h03) ? g1_value : ~rx_g1;
        end
    end
endmodule : soac_far_end

// ---- dv/tb_top.sv ----
/*
 Self-checking bench of the overhead alarm control block.
 Assumes soac_pkg, soac_ctrl and soac_far_end are compiled first.
*/
`timescale 1ns/10ps
`define CHK(got, want, msg) begin \
    n_compared++; \
    if ((got) !== (want)) begin \
        n_errors++; \
        $display("CHECK FAILED at %0t: %s", $time, msg); \
    end \
end
module tb_top;
    import soac_pkg::*;
    logic        clk_sys, reset, framing_sdh, ovr_write, rdi_req;
    logic        yel_auto, ferf_auto, rei_auto, line_bip, path_bip;
    logic        frame_start, rx_g1_valid, tx_line_ferf, sdh_active;
    logic        rdi_alarm, yellow_alarm;
    logic [1:0]  ovr_value, tx_s_bits;
    logic [4:0]  defects, tx_line_febe, defect_ind;
    logic [7:0]  g1_value, rx_g1, tx_g1;
    logic [15:0] line_total, path_total, exp_ltot, exp_ptot;
    int          n_errors, n_compared;

    soac_far_end #(.FRAME_CYC(40)) u_far (
        .clk_sys(clk_sys), .reset(reset), .g1_value(g1_value),
        .frame_start(frame_start), .rx_g1(rx_g1), .rx_g1_valid(rx_g1_valid)
    );

    soac_ctrl u_dut (
        .clk_sys(clk_sys), .reset(reset), .framing_sdh(framing_sdh),
        .s_bits_override_value(ovr_value), .s_bits_override_write(ovr_write),
        .path_yellow_auto_enable(yel_auto),
        .line_remote_defect_auto_enable(ferf_auto),
        .remote_error_auto_enable(rei_auto), .path_rdi_request(rdi_req),
        .frame_start(frame_start), .rx_g1(rx_g1), .rx_g1_valid(rx_g1_valid),
        .los(defects[4]), .lof(defects[3]), .line_ais(defects[2]),
        .lop(defects[1]), .path_ais(defects[0]),
        .line_bip_error(line_bip), .path_bip_error(path_bip),
        .tx_s_bits(tx_s_bits), .tx_g1(tx_g1), .tx_line_ferf(tx_line_ferf),
        .tx_line_febe(tx_line_febe), .framing_sdh_active(sdh_active),
        .defect_indicator(defect_ind), .path_rdi_alarm(rdi_alarm),
        .path_yellow_alarm(yellow_alarm), .line_bip_total(line_total),
        .path_bip_total(path_total)
    );

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic wrap_up;
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    // Wait for a frame start (0) or a received G1 (1), bounded
    task automatic wait_evt(input bit want_valid);
        for (int i = 0; i < 200; i++) begin
            @(posedge clk_sys);
            if (want_valid ? rx_g1_valid : frame_start) return;
        end
        n_errors++;
        $display("CHECK FAILED at %0t: frame event missing", $time);
        wrap_up();
    endtask : wait_evt

    task automatic do_reset;
        @(posedge clk_sys);
        reset <= 1'b1;
        exp_ltot = 16'h0000;
        exp_ptot = 16'h0000;
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        defects <= 5'h10;
        repeat (3) @(negedge clk_sys);
        `CHK(tx_s_bits, S_BITS_SONET, "s bits after reset")
        `CHK(tx_line_ferf, 1'b0, "ferf sent after reset")
        `CHK(sdh_active, 1'b0, "framing after reset")
        `CHK(line_total, 16'h0000, "total after reset")
        `CHK(defect_ind, 5'h10, "indicator after reset")
        @(posedge clk_sys);
        defects <= 5'h00;
    endtask : do_reset

    task automatic t_config;
        wait_evt(1'b0);
        framing_sdh <= 1'b1;
        repeat (3) @(negedge clk_sys);
        `CHK(sdh_active, 1'b0, "framing applied early")
        `CHK(tx_s_bits, S_BITS_SONET, "s bits changed early")
        wait_evt(1'b0);
        @(negedge clk_sys);
        `CHK(sdh_active, 1'b1, "framing not applied")
        `CHK(tx_s_bits, S_BITS_SDH, "sdh s bits")
        for (int v = 0; v < 4; v++) begin
            @(posedge clk_sys);
            ovr_write <= 1'b1;
            ovr_value <= 2'(v);
            @(posedge clk_sys);
            ovr_write <= 1'b0;
            @(negedge clk_sys);
            `CHK(tx_s_bits, 2'(v), "override value")
        end
        wait_evt(1'b0);
        @(negedge clk_sys);
        `CHK(tx_s_bits, 2'h3, "override lost")
        @(posedge clk_sys);
        framing_sdh <= 1'b0;
        wait_evt(1'b0);
        @(negedge clk_sys);
        `CHK(tx_s_bits, S_BITS_SONET, "sonet reload")
        // Override in the frame start cycle of a framing change
        repeat (39) @(posedge clk_sys);
        framing_sdh <= 1'b1;
        ovr_write   <= 1'b1;
        ovr_value   <= 2'h1;
        @(posedge clk_sys);
        ovr_write   <= 1'b0;
        framing_sdh <= 1'b0;
        @(negedge clk_sys);
        `CHK(sdh_active, 1'b1, "framing with override")
        `CHK(tx_s_bits, 2'h1, "override lost to framing")
        wait_evt(1'b0);
        @(negedge clk_sys);
        `CHK(tx_s_bits, S_BITS_SONET, "sonet reload")
    endtask : t_config

    task automatic frames(input logic [7:0] g1, input int n);
        @(posedge clk_sys);
        g1_value <= g1;
        repeat (n) wait_evt(1'b1);
        repeat (2) @(negedge clk_sys);
    endtask : frames

    task automatic t_receive;
        frames(8'h08, 9);
        `CHK(yellow_alarm, 1'b0, "yellow too early")
        frames(8'h08, 1);
        `CHK(yellow_alarm, 1'b1, "yellow not recorded")
        `CHK(rdi_alarm, 1'b0, "bit 5 taken as rdi")
        frames(8'h90, 4);
        `CHK(yellow_alarm, 1'b0, "yellow not dropped")
        `CHK(rdi_alarm, 1'b0, "rdi too early")
        frames(8'h90, 1);
        `CHK(rdi_alarm, 1'b1, "sonet rdi missing")
        @(posedge clk_sys);
        framing_sdh <= 1'b1;
        frames(8'h08, 4);
        `CHK(rdi_alarm, 1'b0, "sdh rdi too early")
        frames(8'h08, 1);
        `CHK(rdi_alarm, 1'b1, "sdh rdi missing")
        `CHK(yellow_alarm, 1'b0, "yellow in sdh")
        frames(8'h00, 1);
        `CHK(rdi_alarm, 1'b0, "sdh rdi not dropped")
    endtask : t_receive

    task automatic t_transmit;
        @(posedge clk_sys);
        rdi_req <= 1'b1;
        repeat (2) @(negedge clk_sys);
        `CHK(tx_g1[3], 1'b1, "sdh rdi bit")
        `CHK(tx_g1[7:4], 4'h0, "sdh rei bits")
        @(posedge clk_sys);
        framing_sdh <= 1'b0;
        wait_evt(1'b0);
        repeat (2) @(negedge clk_sys);
        `CHK(tx_g1, {G1_RDI_SONET, 4'h0}, "sonet rdi pattern")
        @(posedge clk_sys);
        rdi_req <= 1'b0;
    endtask : t_transmit

    task automatic t_auto;
        for (int pass = 0; pass < 3; pass++) begin
            @(posedge clk_sys);
            {yel_auto, ferf_auto} <= {2{pass != 0}};
            framing_sdh <= (pass == 2);
            wait_evt(1'b0);
            for (int i = 0; i < 5; i++) begin
                defects <= 5'h01 << i;
                repeat (2) @(negedge clk_sys);
                `CHK(defect_ind, 5'h01 << i, "indicator")
                `CHK(tx_g1[3], pass == 1, "path yellow")
                `CHK(tx_line_ferf, pass != 0 && i >= 2, "ferf")
                @(posedge clk_sys);
            end
            defects <= 5'h00;
        end
    endtask : t_auto

    task automatic bip_frame(input int nl, input int np,
                             input logic [4:0] el, input logic [3:0] ep);
        wait_evt(1'b0);
        for (int k = 0; k < nl || k < np; k++) begin
            line_bip <= (k < nl);
            path_bip <= (k < np);
            @(posedge clk_sys);
        end
        {line_bip, path_bip} <= 2'b00;
        exp_ltot = exp_ltot + 16'(nl);
        exp_ptot = exp_ptot + 16'(np);
        wait_evt(1'b0);
        @(negedge clk_sys);
        `CHK(tx_line_febe, el, "line febe")
        @(negedge clk_sys);
        `CHK(tx_g1[7:4], ep, "path febe")
        `CHK(line_total, exp_ltot, "line total")
        `CHK(path_total, exp_ptot, "path total")
    endtask : bip_frame

    task automatic t_bip;
        @(posedge clk_sys);
        framing_sdh <= 1'b0;
        bip_frame(3, 2, 5'h00, 4'h0);
        @(posedge clk_sys);
        rei_auto <= 1'b1;
        bip_frame(1, 1, 5'h01, 4'h1);
        bip_frame(26, 10, LINE_FEBE_MAX, PATH_FEBE_MAX);
    endtask : t_bip

    initial begin
        n_errors = 0;
        n_compared = 0;
        reset = 1'b1;
        {framing_sdh, ovr_write, rdi_req, yel_auto} = 4'h0;
        {ferf_auto, rei_auto, line_bip, path_bip} = 4'h0;
        ovr_value = 2'h0;
        defects = 5'h00;
        g1_value = 8'h00;
        do_reset();
        t_config();
        t_receive();
        t_transmit();
        t_auto();
        t_bip();
        do_reset();
        wrap_up();
    end
endmodule : tb_top
